// File: rpd_top.sv
// Purpose: Reset combining, wakeup stretch, straps and clock dividers.
// Assumes: All inputs are synchronous to clk; srst is power-on reset.
// Notes: Register port is a simple strobe port at the documented address.
//
// Behaviour
// RQ1 - Reset from pin or watchdog request.
// RQ2 - Any source restarts timer; hold reset until done.
// RQ3 - Count 4096 clocks, then flash init, then release.
// RQ4 - Pin filter drops short pulses, sets minimum.
// RQ5 - Driver holds pin 10 ms after power-on; the bench model holds it only OSC_START + POR_CYC cycles.
// RQ6 - Driver holds pin 300 ns when oscillator stable.
// RQ7 - Processor fetches from address zero after reset.
// RQ8 - Registers hold reset values at release.
// RQ9 - Straps latch only on external reset.
// RQ10 - Sample trace, return clock, both boot straps.
// RQ11 - Reset aborts flash work, waits high voltage.
// RQ12 - Ratio 00 quarter, 01 full, 10 half.
// RQ13 - Writing 11 to ratio keeps old ratio.
// RQ14 - Ratio field bits 1:0 reset to zero.
// RQ15 - Bits 5:4 choose clock-out pin clock.
// RQ16 - Equal fields give identical clocks.
// RQ17 - Software writes zero to reserved bits.
// RQ18 - Keep the PLL running through idle.
// RQ19 - Ratio change never cuts a clock pulse; the clock-out pin switches source at once when field equality changes.
`timescale 1ns/100ps
`default_nettype none
`include "rpd_regs.svh"
module rpd_top (
   input wire logic clk,
   input wire logic srst,
   input wire logic ext_reset_n,
   input wire logic wdt_reset_req,
   input wire logic osc_running,
   input wire logic flash_busy,
   input wire logic flash_init_done,
   input wire logic flash_hv_settled,
   input wire logic trace_sync_strap_in,
   input wire logic return_clock_strap_in,
   input wire logic boot_select_hi_in,
   input wire logic boot_select_lo_in,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic pin_function_select_two,
   input wire logic addr_bit23,
   input wire logic idle_mode,
   input wire logic pll_running,
   output logic chip_reset,
   output logic flash_init_start,
   output logic flash_abort,
   output logic [31:0] reset_vector,
   output logic trace_sync_strap,
   output logic return_clock_strap,
   output logic boot_select_hi,
   output logic boot_select_lo,
   output logic periph_clk_en,
   output logic periph_clk,
   output logic addr_clock_out_pin,
   output logic pll_keep_run
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic [2:0] low_cnt_reg;      // Consecutive cycles the pin has been low.
   logic ext_filt_reg;           // Filtered external reset level.
   logic ext_start;              // First cycle of a filtered external reset.
   logic src_evt;                // Any new reset event.
   logic div_hit;                // Register access hits the divider.
   logic [7:0] div_reg;          // Divider register as stored.
   rpd_pkg::rpd_ratio_t pratio;  // Peripheral ratio field.
   rpd_pkg::rpd_ratio_t xratio;  // Clock-out ratio field.
   logic xclk_level;             // Clock chosen for the clock-out pin.
   logic [12:0] gap_reg;         // Cycles since the last reset event.

   rpd_div_if p_if ();           // Peripheral divider link.
   rpd_div_if x_if ();           // Clock-out divider link.

   ////////////////////////////////////////////////////////////////////////
   // External reset glitch filter.

   // Count low samples; a pulse shorter than the filter never registers.
   always_ff @(posedge clk) begin
      if (srst || ext_reset_n) begin
         low_cnt_reg <= 3'h0;
      end else if (low_cnt_reg != 3'h7) begin
         low_cnt_reg <= low_cnt_reg + 3'h1;
      end
   end

   // The filtered level rises after the minimum low time, falls on high.
   always_ff @(posedge clk) begin
      if (srst || ext_reset_n) begin
         ext_filt_reg <= 1'b0;
      end else if (low_cnt_reg >= 3'(`RPD_GLITCH_CYC - 1)) begin
         ext_filt_reg <= 1'b1; // RQ4
      end
   end

   // A new external reset is the rising edge of the filtered level.
   assign ext_start = !ext_reset_n && !ext_filt_reg &&
                      low_cnt_reg == 3'(`RPD_GLITCH_CYC - 1);
   // Either source restarts the sequence.
   assign src_evt = ext_start || wdt_reset_req; // RQ1

   ////////////////////////////////////////////////////////////////////////
   // Wakeup timer.

   // Holds chip reset until clock, count, flash and pin release are done.
   rpd_wake_timer u_wake (
      .clk(clk),
      .srst(srst),
      .src_evt(src_evt),
      .ext_hold(ext_filt_reg),
      .osc_ok(osc_running),
      .flash_done(flash_init_done),
      .hv_settled(flash_hv_settled),
      .chip_rst(chip_reset),
      .flash_init(flash_init_start)
   );

   // A reset event during flash program or erase tells flash to abort.
   always_ff @(posedge clk) begin
      if (srst) begin
         flash_abort <= 1'b0;
      end else begin
         flash_abort <= src_evt && flash_busy; // RQ11
      end
   end

   // The processor always restarts from the boot vector address.
   assign reset_vector = `RPD_RESET_VECTOR; // RQ7

   ////////////////////////////////////////////////////////////////////////
   // Configuration straps.

   // Straps follow the pins only while the filtered pin reset is held;
   // a watchdog reset leaves them untouched.
   always_ff @(posedge clk) begin
      if (srst) begin
         trace_sync_strap <= 1'b0;
         return_clock_strap <= 1'b0;
         boot_select_hi <= 1'b0;
         boot_select_lo <= 1'b0;
      end else if (ext_filt_reg) begin
         trace_sync_strap <= trace_sync_strap_in; // RQ9 RQ10
         return_clock_strap <= return_clock_strap_in;
         boot_select_hi <= boot_select_hi_in;
         boot_select_lo <= boot_select_lo_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Divider register.

   assign div_hit = (reg_addr == `RPD_DIV_ADDR);

   // Write: reserved bits are not stored; code 11 leaves a field as is.
   // Chip reset returns the register to its reset value.
   always_ff @(posedge clk) begin
      if (srst || chip_reset) begin
         div_reg <= `RPD_DIV_RESET; // RQ8 RQ14
      end else if (reg_wr && div_hit) begin
         if (reg_wdata[`RPD_PRATIO_MSB:`RPD_PRATIO_LSB] !=
             `RPD_RATIO_RSVD) begin
            div_reg[`RPD_PRATIO_MSB:`RPD_PRATIO_LSB] <=
               reg_wdata[`RPD_PRATIO_MSB:`RPD_PRATIO_LSB]; // RQ13
         end
         if (reg_wdata[`RPD_XRATIO_MSB:`RPD_XRATIO_LSB] !=
             `RPD_RATIO_RSVD) begin
            div_reg[`RPD_XRATIO_MSB:`RPD_XRATIO_LSB] <=
               reg_wdata[`RPD_XRATIO_MSB:`RPD_XRATIO_LSB]; // RQ15
         end
      end
   end

   // Read data is registered; reserved bits and other addresses read zero.
   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd && div_hit) begin
         reg_rdata <= div_reg;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   assign pratio = div_reg[`RPD_PRATIO_MSB:`RPD_PRATIO_LSB];
   assign xratio = div_reg[`RPD_XRATIO_MSB:`RPD_XRATIO_LSB];

   ////////////////////////////////////////////////////////////////////////
   // Clock dividers.

   assign p_if.ratio = pratio; // RQ12
   assign x_if.ratio = xratio; // RQ15

   // Peripheral clock divider.
   rpd_clk_div u_pdiv (
      .clk(clk),
      .srst(srst),
      .port(p_if.div)
   );

   // Clock-out divider.
   rpd_clk_div u_xdiv (
      .clk(clk),
      .srst(srst),
      .port(x_if.div)
   );

   assign periph_clk_en = p_if.tick;
   assign periph_clk = p_if.level;

   // Equal fields share the peripheral clock so both edges line up.
   assign xclk_level = (xratio == pratio) ? p_if.level : x_if.level; // RQ16

   // The shared pin carries the address bit or the selected clock.
   assign addr_clock_out_pin = pin_function_select_two ? xclk_level :
                               addr_bit23; // RQ15

   ////////////////////////////////////////////////////////////////////////
   // PLL hold in idle.

   // The PLL state is frozen on entry to idle so a running PLL stays on.
   always_ff @(posedge clk) begin
      if (srst) begin
         pll_keep_run <= 1'b0;
      end else if (!idle_mode) begin
         pll_keep_run <= pll_running; // RQ18
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   // Cycles since the last reset event, saturating.
   always_ff @(posedge clk) begin
      if (srst || src_evt) begin
         gap_reg <= 13'h0000;
      end else if (gap_reg != 13'h1FFF) begin
         gap_reg <= gap_reg + 13'h0001;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   AST_WDT_RESET: assert property ( // RQ1
      wdt_reset_req |=> chip_reset[*3])
      else $error("Watchdog request did not hold chip reset.");

   AST_EXT_HOLD: assert property ( // RQ2
      ext_filt_reg |=> chip_reset)
      else $error("Chip reset released while pin reset held.");

   AST_WAKE_COUNT: assert property ( // RQ3
      flash_init_start |-> gap_reg >= 13'h1000)
      else $error("Flash started before the wakeup count.");

   AST_GLITCH_DROP: assert property ( // RQ4
      ext_reset_n ##1 !ext_reset_n ##1 ext_reset_n |=> !ext_filt_reg)
      else $error("Single-cycle reset pulse was accepted.");

   AST_GLITCH_TAKE: assert property ( // RQ4
      (!ext_reset_n)[*2] |=> ext_filt_reg)
      else $error("Two-cycle reset pulse was not accepted.");

   AST_STRAP_KEEP: assert property ( // RQ9
      !ext_filt_reg |=> $stable({trace_sync_strap, return_clock_strap,
                                 boot_select_hi, boot_select_lo}))
      else $error("Straps changed outside external reset.");

   AST_STRAP_TAKE: assert property ( // RQ10
      ext_filt_reg |=> boot_select_lo == $past(boot_select_lo_in) &&
                       trace_sync_strap == $past(trace_sync_strap_in))
      else $error("Straps not sampled during external reset.");

   AST_ABORT: assert property ( // RQ11
      src_evt && flash_busy |=> flash_abort && chip_reset)
      else $error("Flash not aborted on reset.");

   AST_RSVD_WRITE: assert property ( // RQ13
      reg_wr && div_hit && reg_wdata[1:0] == 2'h3 && !chip_reset
      |=> pratio == $past(pratio))
      else $error("Reserved ratio write changed the ratio.");

   AST_RESET_ZERO: assert property ( // RQ14
      $fell(chip_reset) |-> div_reg == 8'h00)
      else $error("Divider not zero at reset release.");

   AST_QUARTER: assert property ( // RQ12
      periph_clk_en && pratio == 2'h0 |=> (!periph_clk_en)[*3] ##1
      periph_clk_en)
      else $error("Quarter ratio period is not four cycles.");

   AST_SAME_CLK: assert property ( // RQ16
      pin_function_select_two && xratio == pratio
      |-> addr_clock_out_pin == periph_clk)
      else $error("Clock-out differs from peripheral clock.");

   COV_WDT: cover property (wdt_reset_req && flash_busy ##1 flash_abort);
   COV_HALF: cover property (periph_clk_en && pratio == 2'h2);
   COV_EXT: cover property ($rose(ext_filt_reg) ##[1:20] ext_reset_n);
endmodule
`default_nettype wire

// File: rpd_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Included by the design files of the reset and divider block.
// Notes: Definitions only; no logic lives here.
`ifndef RPD_REGS_SVH
`define RPD_REGS_SVH

// Byte address of the peripheral clock divider register.
`define RPD_DIV_ADDR 32'hE01F_C100
// Reset value of the whole divider register.
`define RPD_DIV_RESET 8'h00
// Peripheral clock ratio field, bits 1:0.
`define RPD_PRATIO_LSB 0
`define RPD_PRATIO_MSB 1
// Clock-out ratio field, bits 5:4.
`define RPD_XRATIO_LSB 4
`define RPD_XRATIO_MSB 5
// Ratio encodings.
`define RPD_RATIO_QUARTER 2'h0
`define RPD_RATIO_FULL 2'h1
`define RPD_RATIO_HALF 2'h2
`define RPD_RATIO_RSVD 2'h3
// Address the processor fetches from when internal reset ends.
`define RPD_RESET_VECTOR 32'h0000_0000
// Clock period in ns and the shortest pulse the reset filter accepts.
`define RPD_CLK_NS 50
`define RPD_GLITCH_NS 100
`define RPD_GLITCH_CYC ((`RPD_GLITCH_NS + `RPD_CLK_NS - 1) / `RPD_CLK_NS)
// Clocks counted by the wakeup timer once the oscillator runs.
`define RPD_WAKE_CLOCKS 4096

`endif

// File: rpd_pkg.sv
// Purpose: Types shared by the reset and divider block.
// Assumes: Nothing beyond the language.
// Notes: Constants live in rpd_regs.svh.
package rpd_pkg;
   // Two-bit divider ratio code.
   typedef logic [1:0] rpd_ratio_t;
   // Wakeup timer states.
   typedef enum logic [2:0] {
      WT_HOLD, WT_COUNT, WT_FLASH, WT_RELEASE, WT_RUN
   } rpd_wake_state_t;
endpackage

// File: rpd_div_if.sv
// Purpose: Carries a ratio to one divider and its clock back.
// Assumes: One clock domain.
// Notes: ctrl is the register side, div is the divider side.
`timescale 1ns/100ps
`default_nettype none
interface rpd_div_if;
   rpd_pkg::rpd_ratio_t ratio; // Requested ratio from the register.
   logic tick;                 // One-cycle pulse per divided period.
   logic level;                // Divided clock as a level.
   modport ctrl (output ratio, input tick, input level);
   modport div (input ratio, output tick, output level);
endinterface
`default_nettype wire

// File: rpd_clk_div.sv
// Purpose: Divides the processor clock by 1, 2 or 4 as an enable pulse.
// Assumes: Ratio code comes from a register in the same domain.
// Notes: A new ratio is taken only at the end of a period.
`timescale 1ns/100ps
`default_nettype none
`include "rpd_regs.svh"
module rpd_clk_div (
   input wire logic clk,
   input wire logic srst,
   rpd_div_if.div port
);
   logic [1:0] cnt_reg;              // Position inside the current period.
   rpd_pkg::rpd_ratio_t act_reg;     // Ratio of the period in progress.
   logic [1:0] last;                 // Final count of this period.

   // Final count of the period for the active ratio.
   always_comb begin
      case (act_reg)
         `RPD_RATIO_FULL: last = 2'h0;
         `RPD_RATIO_HALF: last = 2'h1;
         default: last = 2'h3;
      endcase
   end

   // Period counter; wraps at the final count.
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_reg <= 2'h0;
      end else if (cnt_reg == last) begin
         cnt_reg <= 2'h0;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
      end
   end

   // A ratio change waits for the period boundary, so no pulse is cut.
   always_ff @(posedge clk) begin
      if (srst) begin
         act_reg <= `RPD_RATIO_QUARTER;
      end else if (cnt_reg == last && port.ratio != `RPD_RATIO_RSVD) begin
         act_reg <= port.ratio; // RQ19
      end
   end

   // Tick at each period end; level is high in the first half period.
   assign port.tick = (cnt_reg == last); // RQ12
   assign port.level = (act_reg == `RPD_RATIO_FULL) ? 1'b1 :
                       (cnt_reg <= {1'b0, last[1]});
endmodule
`default_nettype wire

// File: rpd_wake_timer.sv
// Purpose: Stretches internal reset until clock, count and flash are done.
// Assumes: The reset event and the held external reset are filtered.
// Notes: A new reset event always restarts the sequence.
`timescale 1ns/100ps
`default_nettype none
`include "rpd_regs.svh"
module rpd_wake_timer (
   input wire logic clk,
   input wire logic srst,
   input wire logic src_evt,
   input wire logic ext_hold,
   input wire logic osc_ok,
   input wire logic flash_done,
   input wire logic hv_settled,
   output logic chip_rst,
   output logic flash_init
);
   rpd_pkg::rpd_wake_state_t state_reg; // Sequence position.
   logic [11:0] cnt_reg;                // Clocks counted since clock seen.

   // Sequence: wait clock, count, initialise flash, await pin release.
   always_ff @(posedge clk) begin
      if (srst || src_evt) begin
         state_reg <= rpd_pkg::WT_HOLD; // RQ2
      end else begin
         case (state_reg)
            rpd_pkg::WT_HOLD: begin
               if (osc_ok) begin
                  state_reg <= rpd_pkg::WT_COUNT;
               end
            end
            rpd_pkg::WT_COUNT: begin
               if (!osc_ok) begin
                  state_reg <= rpd_pkg::WT_HOLD;
               end else if (cnt_reg == 12'(`RPD_WAKE_CLOCKS - 1)) begin
                  state_reg <= rpd_pkg::WT_FLASH; // RQ3
               end
            end
            rpd_pkg::WT_FLASH: begin
               if (flash_done) begin
                  state_reg <= rpd_pkg::WT_RELEASE;
               end
            end
            rpd_pkg::WT_RELEASE: begin
               if (!ext_hold && hv_settled) begin
                  state_reg <= rpd_pkg::WT_RUN; // RQ3 RQ11
               end
            end
            rpd_pkg::WT_RUN: state_reg <= rpd_pkg::WT_RUN;
            default: state_reg <= rpd_pkg::WT_HOLD;
         endcase
      end
   end

   // Clock counter runs only while counting.
   always_ff @(posedge clk) begin
      if (srst || state_reg != rpd_pkg::WT_COUNT) begin
         cnt_reg <= 12'h000;
      end else begin
         cnt_reg <= cnt_reg + 12'h001;
      end
   end

   // Flash start is a one-cycle pulse at the end of the count.
   always_ff @(posedge clk) begin
      if (srst || src_evt) begin
         flash_init <= 1'b0;
      end else begin
         flash_init <= state_reg == rpd_pkg::WT_COUNT && osc_ok &&
                       cnt_reg == 12'(`RPD_WAKE_CLOCKS - 1); // RQ3
      end
   end

   assign chip_rst = (state_reg != rpd_pkg::WT_RUN); // RQ2
endmodule
`default_nettype wire

// File: rpd_osc_reset_model.sv
// Purpose: Model of the external reset circuit and the crystal oscillator.
// Assumes: A go strobe is set at a falling edge and sampled at a rising one.
// Notes: The power-on hold is shortened to OSC_START + POR_CYC cycles.
`timescale 1ns/100ps
`default_nettype none
module rpd_osc_reset_model #(
   parameter int OSC_START = 40,
   parameter int POR_CYC = 4300
) (
   input wire logic clk,
   input wire logic go,
   input wire logic [15:0] len,
   output logic ext_reset_n,
   output logic osc_running
);
   ////////////////////////////////////////////////////////////////////////
   // One process drives both pins, so no two drivers can collide.
   initial begin
      ext_reset_n = 1'b0;
      osc_running = 1'b0;
      repeat (OSC_START) @(negedge clk);
      osc_running = 1'b1;
      // The pin is let go only once the oscillator has been running a while.
      repeat (POR_CYC) @(negedge clk);
      ext_reset_n = 1'b1;
      forever begin
         @(posedge clk);
         if (go === 1'b1) begin
            @(negedge clk);
            // Commanded pulse; six cycles meets the stable-clock minimum.
            ext_reset_n = 1'b0;
            repeat (len) @(negedge clk);
            ext_reset_n = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for the reset and divider block.
// Assumes: Inputs change at the falling edge; outputs are read there too.
// Notes: Register values are four fixed corners, then drawn at random from a fixed seed.
`timescale 1ns/100ps
`default_nettype none
`include "rpd_regs.svh"
module testbench;
   localparam int LIMIT = 20000; // Cycle ceiling for a hung run.
   localparam int POR_CYC = 4300; // Shortened power-on pin hold.
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic wdt_reset_req = 1'b0, flash_busy = 1'b0, flash_init_done = 1'b1;
   logic flash_hv_settled = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] straps_in = 4'h0; // Trace, return clock, boot hi, boot lo.
   logic [31:0] reg_addr = `RPD_DIV_ADDR;
   logic [7:0] reg_wdata = 8'h00;
   logic pin_function_select_two = 1'b0, addr_bit23 = 1'b0;
   logic idle_mode = 1'b0, pll_running = 1'b0, go = 1'b0;
   logic [15:0] len = 16'h0000;
   logic ext_reset_n, osc_running, chip_reset, flash_init_start, flash_abort;
   logic [31:0] reset_vector;
   logic [7:0] reg_rdata;
   logic trace_sync_strap, return_clock_strap, boot_select_hi;
   logic boot_select_lo, periph_clk_en, periph_clk, addr_clock_out_pin;
   logic pll_keep_run;
   int err_count = 0, compares = 0, cycles = 0, seed = 89;
   int init_cyc = 0, ev_cyc = 0; // Cycle of last flash start and event.

   // The clock toggles every half period of 25 ns.
   always #25 clk = ~clk;

   rpd_osc_reset_model #(.POR_CYC(POR_CYC)) rpd_osc_reset_model_inst (
      .clk(clk), .go(go), .len(len), .ext_reset_n(ext_reset_n),
      .osc_running(osc_running));

   rpd_top rpd_top_inst (
      .clk(clk), .srst(srst), .ext_reset_n(ext_reset_n),
      .wdt_reset_req(wdt_reset_req), .osc_running(osc_running),
      .flash_busy(flash_busy), .flash_init_done(flash_init_done),
      .flash_hv_settled(flash_hv_settled),
      .trace_sync_strap_in(straps_in[3]),
      .return_clock_strap_in(straps_in[2]),
      .boot_select_hi_in(straps_in[1]), .boot_select_lo_in(straps_in[0]),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .pin_function_select_two(pin_function_select_two),
      .addr_bit23(addr_bit23), .idle_mode(idle_mode),
      .pll_running(pll_running), .chip_reset(chip_reset),
      .flash_init_start(flash_init_start), .flash_abort(flash_abort),
      .reset_vector(reset_vector), .trace_sync_strap(trace_sync_strap),
      .return_clock_strap(return_clock_strap),
      .boot_select_hi(boot_select_hi), .boot_select_lo(boot_select_lo),
      .periph_clk_en(periph_clk_en), .periph_clk(periph_clk),
      .addr_clock_out_pin(addr_clock_out_pin), .pll_keep_run(pll_keep_run));

   ////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("counts: %0d compares, %0d mismatches", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // A hang counts as a mismatch and goes to the closing report.
   always @(posedge clk) begin
      cycles++;
      if (flash_init_start === 1'b1)
         init_cyc = cycles;
      if (cycles == LIMIT) begin
         err_count++;
         wrap_up();
      end
   end

   // Compares a seen value with the expected one, case-equal.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Division factor of a ratio code.
   function automatic int div_of(input logic [1:0] r);
      return (r == `RPD_RATIO_FULL) ? 1 : (r == `RPD_RATIO_HALF) ? 2 : 4;
   endfunction

   // Rising edges of a divided clock level seen in eight cycles.
   function automatic int rises(input logic [1:0] r);
      return (r == `RPD_RATIO_FULL) ? 0 : 8 / div_of(r);
   endfunction

   // Register after a write: code 11 keeps a field, reserved bits stay 0.
   function automatic logic [7:0] next_reg(input logic [7:0] o, input logic [7:0] w);
      next_reg = o & 8'h33;
      if (w[1:0] != `RPD_RATIO_RSVD)
         next_reg[1:0] = w[1:0];
      if (w[5:4] != `RPD_RATIO_RSVD)
         next_reg[5:4] = w[5:4];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register strobes last one cycle and start one edge after the call.
   task automatic reg_write(input logic [31:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   // Read data is registered, so it is taken one cycle after the strobe.
   task automatic reg_read(input logic [31:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask

   // Waits, bounded, for internal reset to end and checks the init order.
   task automatic wait_release(output int n);
      n = 0;
      while (chip_reset !== 1'b0 && n < 6000) begin
         @(negedge clk);
         n++;
      end
      check(chip_reset, 1'b0);
      check(init_cyc - ev_cyc >= `RPD_WAKE_CLOCKS, 1'b1);
   endtask

   // Counts enables, clock rises, pin rises and pin-equals-clock cycles.
   task automatic count8(output int en, output int pr, output int xr,
                         output int eq);
      logic lp, lx;
      en = 0;
      pr = 0;
      xr = 0;
      eq = 0;
      lp = periph_clk;
      lx = addr_clock_out_pin;
      repeat (8) begin
         @(negedge clk);
         en += (periph_clk_en === 1'b1);
         pr += (periph_clk === 1'b1 && lp === 1'b0);
         xr += (addr_clock_out_pin === 1'b1 && lx === 1'b0);
         eq += (addr_clock_out_pin === periph_clk);
         lp = periph_clk;
         lx = addr_clock_out_pin;
      end
   endtask

   // Issues one commanded pulse on the external reset pin.
   task automatic pin_pulse(input logic [15:0] cycles_low);
      @(negedge clk);
      go = 1'b1;
      len = cycles_low;
      @(negedge clk);
      go = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence: power-on, register traffic, pin, resets and idle.
   initial begin
      int n, en, pr, xr, eq;
      logic [7:0] rd, model, w;
      logic [3:0] sv;
      logic [7:0] corner [4] = '{8'h13, 8'h31, 8'h22, 8'h00};
      repeat (4) @(negedge clk);
      srst = 1'b0;
      reg_write(`RPD_DIV_ADDR, 8'h11);
      check(chip_reset, 1'b1);
      wait_release(n);
      check(n + 6 >= POR_CYC, 1'b1);
      check(reset_vector, `RPD_RESET_VECTOR);
      reg_read(`RPD_DIV_ADDR, rd);
      check(rd, `RPD_DIV_RESET);
      count8(en, pr, xr, eq);
      check(en, 2);
      $display("test power_on done");
      model = `RPD_DIV_RESET;
      pin_function_select_two = 1'b1;
      for (int i = 0; i < 16; i++) begin
         w = (i < 4) ? corner[i] : ($random(seed) & 8'h33);
         model = next_reg(model, w);
         reg_write(`RPD_DIV_ADDR, w);
         reg_read(`RPD_DIV_ADDR, rd);
         check(rd, model);
         repeat (6) @(negedge clk);
         count8(en, pr, xr, eq);
         check(en, 8 / div_of(model[1:0]));
         check(pr, rises(model[1:0]));
         check(xr, rises(model[5:4]));
         if (model[1:0] == model[5:4])
            check(eq, 8);
      end
      reg_write(`RPD_DIV_ADDR + 32'h4, 8'h12);
      reg_read(`RPD_DIV_ADDR + 32'h4, rd);
      check(rd, 8'h00);
      reg_read(`RPD_DIV_ADDR, rd);
      check(rd, model);
      pin_function_select_two = 1'b0;
      for (int b = 0; b < 2; b++) begin
         addr_bit23 = b[0];
         @(negedge clk);
         check(addr_clock_out_pin, b[0]);
      end
      $display("test divider done");
      pin_pulse(16'h0001);
      n = 0;
      repeat (6) begin
         @(negedge clk);
         n += (chip_reset === 1'b1);
      end
      check(n, 0);
      $display("test glitch done");
      straps_in = $random(seed);
      sv = straps_in;
      pin_pulse(16'h0006);
      ev_cyc = cycles;
      repeat (5) @(negedge clk);
      check(chip_reset, 1'b1);
      wait_release(n);
      check({trace_sync_strap, return_clock_strap, boot_select_hi,
             boot_select_lo}, sv);
      reg_read(`RPD_DIV_ADDR, rd);
      check(rd, `RPD_DIV_RESET);
      $display("test external_reset done");
      reg_write(`RPD_DIV_ADDR, 8'h21);
      straps_in = ~sv;
      flash_busy = 1'b1;
      flash_hv_settled = 1'b0;
      @(negedge clk);
      wdt_reset_req = 1'b1;
      ev_cyc = cycles;
      @(negedge clk);
      wdt_reset_req = 1'b0;
      n = 0;
      repeat (3) begin
         n += (flash_abort === 1'b1);
         @(negedge clk);
      end
      check(n, 1);
      flash_busy = 1'b0;
      check(chip_reset, 1'b1);
      repeat (4200) @(negedge clk);
      check(chip_reset, 1'b1);
      flash_hv_settled = 1'b1;
      wait_release(n);
      check({trace_sync_strap, return_clock_strap, boot_select_hi,
             boot_select_lo}, sv);
      reg_read(`RPD_DIV_ADDR, rd);
      check(rd, `RPD_DIV_RESET);
      $display("test watchdog_reset done");
      pll_running = 1'b1;
      repeat (2) @(negedge clk);
      check(pll_keep_run, 1'b1);
      idle_mode = 1'b1;
      pll_running = 1'b0;
      repeat (2) @(negedge clk);
      check(pll_keep_run, 1'b1);
      idle_mode = 1'b0;
      repeat (2) @(negedge clk);
      check(pll_keep_run, 1'b0);
      $display("test idle done");
      wrap_up();
   end
endmodule
`default_nettype wire
